// >>> hdl/sbtc_pkg.sv
// Purpose: constants for the 16-bit timer/counter core
// Assumes: byte-wide register bus mapped onto Avalon-MM word slots
// Notes: one register per aligned 32-bit word, data in bits 7:0
package sbtc_pkg;
  // register byte addresses (word aligned)
  localparam logic [5:0] ADDR_CTRL_A = 6'h00;
  localparam logic [5:0] ADDR_CTRL_B = 6'h04;
  localparam logic [5:0] ADDR_CNT_LO = 6'h08;
  localparam logic [5:0] ADDR_CNT_HI = 6'h0C;
  localparam logic [5:0] ADDR_CMPA_LO = 6'h10;
  localparam logic [5:0] ADDR_CMPA_HI = 6'h14;
  localparam logic [5:0] ADDR_CMPB_LO = 6'h18;
  localparam logic [5:0] ADDR_CMPB_HI = 6'h1C;
  localparam logic [5:0] ADDR_CAP_LO = 6'h20;
  localparam logic [5:0] ADDR_CAP_HI = 6'h24;
  localparam logic [5:0] ADDR_MASK = 6'h28;
  localparam logic [5:0] ADDR_FLAG = 6'h2C;
  // flag and mask bit positions
  localparam int BIT_OVF = 0;
  localparam int BIT_CMPA = 1;
  localparam int BIT_CMPB = 2;
  localparam int BIT_CAP = 3;
  // control field positions
  localparam int CTRL_A_WGM_LO = 0;
  localparam int CTRL_B_WGM_HI = 3;
  localparam int CTRL_B_EDGE = 6;
  localparam int CTRL_B_CS = 0;
  // fixed values
  localparam logic [15:0] CNT_MAX = 16'h00FF;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [3:0] RST_FLAGS = 4'h0;
  // clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  // prescaler divide counts
  localparam logic [9:0] DIV_8 = 10'h007;
  localparam logic [9:0] DIV_64 = 10'h03F;
  localparam logic [9:0] DIV_256 = 10'h0FF;
  localparam logic [9:0] DIV_1024 = 10'h3FF;
  // waveform mode codes
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [3:0] WGM_PC_MAX = 4'h3;
  localparam logic [3:0] WGM_CTC_A = 4'h4;
  localparam logic [3:0] WGM_FAST_MAX = 4'h7;
  localparam logic [3:0] WGM_PFC_CAP = 4'h8;
  localparam logic [3:0] WGM_PFC_A = 4'h9;
  localparam logic [3:0] WGM_PC_CAP = 4'hA;
  localparam logic [3:0] WGM_PC_A = 4'hB;
  localparam logic [3:0] WGM_CTC_CAP = 4'hC;
  localparam logic [3:0] WGM_FAST_CAP = 4'hE;
  localparam logic [3:0] WGM_FAST_A = 4'hF;
endpackage : sbtc_pkg

// >>> hdl/sbtc_core.sv
// Purpose: 16-bit timer/counter core with byte access over Avalon-MM
// Assumes: single 100 MHz clock, synchronous active-low reset, inputs synchronous
// Notes: waveform pin logic and noise filter are outside this core
`timescale 1ns/100ps
module sbtc_core (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // avalon-mm slave
  input wire logic [5:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  output logic [1:0] o_response,
  // timer pins
  input wire logic i_external_count_input,
  input wire logic i_capture_input_pin,
  input wire logic i_comparator_out,
  input wire logic i_capture_use_comparator,
  input wire logic [3:0] i_irq_ack,
  // status
  output logic [3:0] o_irq,
  output logic o_top,
  output logic o_bottom,
  output logic o_max,
  output logic o_match_a,
  output logic o_match_b,
  output logic o_pwm_a_enable
);
  logic [7:0] ctrl_a_reg;
  logic [7:0] ctrl_b_reg;
  logic [15:0] count_value_reg;
  logic [15:0] cmpa_buf_reg;
  logic [15:0] compare_a_value_reg;
  logic [15:0] compare_b_value_reg;
  logic [15:0] capture_value_reg;
  logic [7:0] latch_reg;
  logic [3:0] flag_reg;
  logic [3:0] mask_reg;
  logic down_reg;
  logic ack_reg;
  logic [9:0] presc_reg;
  logic ext_reg;
  logic cap_src_reg;
  logic cmp_block_reg;
  logic [2:0] cs;
  logic [3:0] wgm;
  logic timer_tick;
  logic [15:0] top_value;
  logic pwm_mode;
  logic dual_slope;
  logic a_is_top;
  logic top_hit;
  logic bot_hit;
  logic [15:0] count_next;
  logic down_next;
  logic ovf_set;
  logic cap_src;
  logic cap_edge;
  logic wr_en;
  logic rd_en;
  logic [7:0] wbyte;
  logic [7:0] rdata_next;
  logic cap_is_top;
  logic [3:0] flag_set;
  logic [3:0] flag_clr;
  logic [3:0] flag_next;

  assign cs = ctrl_b_reg[sbtc_pkg::CTRL_B_CS +: 3];
  assign wgm = {ctrl_b_reg[sbtc_pkg::CTRL_B_WGM_HI +: 2], ctrl_a_reg[sbtc_pkg::CTRL_A_WGM_LO +: 2]};
  assign wr_en = i_write && ack_reg && i_byteenable[0];
  assign rd_en = i_read && !ack_reg;
  assign wbyte = i_writedata[7:0];
  assign o_waitrequest = !ack_reg;
  assign o_response = 2'h0;

  // mode decode
  always_comb begin
    pwm_mode = (wgm != sbtc_pkg::WGM_NORMAL) && (wgm != sbtc_pkg::WGM_CTC_A)
      && (wgm != sbtc_pkg::WGM_CTC_CAP);
    dual_slope = (wgm[3:2] == 2'h0 && wgm[1:0] != 2'h0) || (wgm[3:2] == 2'h2);
    a_is_top = (wgm == sbtc_pkg::WGM_CTC_A) || (wgm == sbtc_pkg::WGM_PFC_A)
      || (wgm == sbtc_pkg::WGM_PC_A) || (wgm == sbtc_pkg::WGM_FAST_A);
    cap_is_top = (wgm == sbtc_pkg::WGM_PFC_CAP) || (wgm == sbtc_pkg::WGM_PC_CAP)
      || (wgm == sbtc_pkg::WGM_CTC_CAP) || (wgm == sbtc_pkg::WGM_FAST_CAP);
    case (wgm)
      sbtc_pkg::WGM_NORMAL: top_value = 16'hFFFF;
      sbtc_pkg::WGM_CTC_A, sbtc_pkg::WGM_PFC_A, sbtc_pkg::WGM_PC_A,
      sbtc_pkg::WGM_FAST_A: top_value = compare_a_value_reg;
      sbtc_pkg::WGM_PFC_CAP, sbtc_pkg::WGM_PC_CAP, sbtc_pkg::WGM_CTC_CAP,
      sbtc_pkg::WGM_FAST_CAP: top_value = capture_value_reg;
      default: top_value = sbtc_pkg::CNT_MAX;
    endcase
  end

  assign top_hit = (count_value_reg == top_value);
  assign bot_hit = (count_value_reg == sbtc_pkg::CNT_BOTTOM);
  assign o_top = top_hit;
  assign o_bottom = bot_hit;
  assign o_max = (count_value_reg == sbtc_pkg::CNT_MAX);
  assign o_match_a = (count_value_reg == compare_a_value_reg);
  assign o_match_b = (count_value_reg == compare_b_value_reg);
  assign o_pwm_a_enable = pwm_mode && !a_is_top;
  assign o_irq = flag_reg & mask_reg;

  // clock select and prescaler taps
  always_comb begin
    case (cs)
      sbtc_pkg::CS_STOP: timer_tick = 1'b0;
      3'h1: timer_tick = 1'b1;
      3'h2: timer_tick = (presc_reg[2:0] == sbtc_pkg::DIV_8[2:0]);
      3'h3: timer_tick = (presc_reg[5:0] == sbtc_pkg::DIV_64[5:0]);
      3'h4: timer_tick = (presc_reg[7:0] == sbtc_pkg::DIV_256[7:0]);
      3'h5: timer_tick = (presc_reg == sbtc_pkg::DIV_1024);
      sbtc_pkg::CS_EXT_FALL: timer_tick = ext_reg && !i_external_count_input;
      sbtc_pkg::CS_EXT_RISE: timer_tick = !ext_reg && i_external_count_input;
      default: timer_tick = 1'b0;
    endcase
  end

  // next count and direction
  always_comb begin
    count_next = count_value_reg;
    down_next = down_reg;
    ovf_set = 1'b0;
    if (timer_tick) begin
      if (dual_slope) begin
        if (top_hit) begin
          down_next = 1'b1;
          count_next = count_value_reg - 16'h0001;
          ovf_set = 1'b0;
        end else if (bot_hit && down_reg) begin
          down_next = 1'b0;
          count_next = count_value_reg + 16'h0001;
          ovf_set = 1'b1;
        end else if (down_reg) begin
          count_next = count_value_reg - 16'h0001;
        end else begin
          count_next = count_value_reg + 16'h0001;
        end
      end else if (top_hit) begin
        count_next = sbtc_pkg::CNT_BOTTOM;
        ovf_set = pwm_mode || (wgm == sbtc_pkg::WGM_NORMAL);
        down_next = 1'b0;
      end else begin
        count_next = count_value_reg + 16'h0001;
        down_next = 1'b0;
      end
    end
  end

  // capture source and edge
  assign cap_src = i_capture_use_comparator ? i_comparator_out : i_capture_input_pin;
  assign cap_edge = (cap_src != cap_src_reg)
    && (cap_src == ctrl_b_reg[sbtc_pkg::CTRL_B_EDGE]);

  // bus handshake: one wait cycle then acknowledge
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (i_read || i_write) && !ack_reg;
    end
  end

  // read data mux
  always_comb begin
    case (i_address)
      sbtc_pkg::ADDR_CTRL_A: rdata_next = ctrl_a_reg;
      sbtc_pkg::ADDR_CTRL_B: rdata_next = ctrl_b_reg;
      sbtc_pkg::ADDR_CNT_LO: rdata_next = count_value_reg[7:0];
      sbtc_pkg::ADDR_CNT_HI: rdata_next = latch_reg;
      sbtc_pkg::ADDR_CMPA_LO: rdata_next = cmpa_buf_reg[7:0];
      sbtc_pkg::ADDR_CMPA_HI: rdata_next = cmpa_buf_reg[15:8];
      sbtc_pkg::ADDR_CMPB_LO: rdata_next = compare_b_value_reg[7:0];
      sbtc_pkg::ADDR_CMPB_HI: rdata_next = compare_b_value_reg[15:8];
      sbtc_pkg::ADDR_CAP_LO: rdata_next = capture_value_reg[7:0];
      sbtc_pkg::ADDR_CAP_HI: rdata_next = latch_reg;
      sbtc_pkg::ADDR_MASK: rdata_next = {4'h0, mask_reg};
      sbtc_pkg::ADDR_FLAG: rdata_next = {4'h0, flag_reg};
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_readdata <= 32'h0000_0000;
    end else if (i_read && !ack_reg) begin
      o_readdata <= {24'h00_0000, rdata_next};
    end
  end

  // control registers
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      ctrl_a_reg <= sbtc_pkg::RST_BYTE;
      ctrl_b_reg <= sbtc_pkg::RST_BYTE;
      mask_reg <= 4'h0;
    end else if (wr_en) begin
      if (i_address == sbtc_pkg::ADDR_CTRL_A) ctrl_a_reg <= wbyte;
      if (i_address == sbtc_pkg::ADDR_CTRL_B) ctrl_b_reg <= wbyte;
      if (i_address == sbtc_pkg::ADDR_MASK) mask_reg <= wbyte[3:0];
    end
  end

  // shared high-byte latch
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      latch_reg <= sbtc_pkg::RST_BYTE;
    end else if (wr_en && (i_address == sbtc_pkg::ADDR_CNT_HI
        || i_address == sbtc_pkg::ADDR_CMPA_HI || i_address == sbtc_pkg::ADDR_CMPB_HI
        || i_address == sbtc_pkg::ADDR_CAP_HI)) begin
      latch_reg <= wbyte;
    end else if (rd_en && i_address == sbtc_pkg::ADDR_CNT_LO) begin
      latch_reg <= count_value_reg[15:8];
    end else if (rd_en && i_address == sbtc_pkg::ADDR_CAP_LO) begin
      latch_reg <= capture_value_reg[15:8];
    end
  end

  // counter, direction and prescaler
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      count_value_reg <= sbtc_pkg::RST_WORD;
      down_reg <= 1'b0;
      presc_reg <= 10'h000;
      ext_reg <= 1'b0;
    end else begin
      presc_reg <= (cs == sbtc_pkg::CS_STOP) ? 10'h000 : presc_reg + 10'h001;
      ext_reg <= i_external_count_input;
      if (wr_en && i_address == sbtc_pkg::ADDR_CNT_LO) begin
        count_value_reg <= {latch_reg, wbyte};
      end else begin
        count_value_reg <= count_next;
        down_reg <= down_next;
      end
    end
  end

  // compare registers; a is buffered in pwm modes
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      cmpa_buf_reg <= sbtc_pkg::RST_WORD;
      compare_a_value_reg <= sbtc_pkg::RST_WORD;
      compare_b_value_reg <= sbtc_pkg::RST_WORD;
    end else begin
      if (wr_en && i_address == sbtc_pkg::ADDR_CMPA_LO) begin
        cmpa_buf_reg <= {latch_reg, wbyte};
        if (!pwm_mode) compare_a_value_reg <= {latch_reg, wbyte};
      end else if (pwm_mode && timer_tick && top_hit) begin
        compare_a_value_reg <= cmpa_buf_reg;
      end
      if (wr_en && i_address == sbtc_pkg::ADDR_CMPB_LO) begin
        compare_b_value_reg <= {latch_reg, wbyte};
      end
    end
  end

  // capture register
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      capture_value_reg <= sbtc_pkg::RST_WORD;
      cap_src_reg <= 1'b0;
    end else begin
      cap_src_reg <= cap_src;
      if (wr_en && i_address == sbtc_pkg::ADDR_CAP_LO) begin
        capture_value_reg <= {latch_reg, wbyte};
      end else if (cap_edge && !cap_is_top) begin
        capture_value_reg <= count_value_reg;
      end
    end
  end

  // a count write blocks compare flags on the next tick
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      cmp_block_reg <= 1'b0;
    end else if (wr_en && i_address == sbtc_pkg::ADDR_CNT_LO) begin
      cmp_block_reg <= 1'b1;
    end else if (timer_tick) begin
      cmp_block_reg <= 1'b0;
    end
  end

  // flag set strobes; a match flags on the tick that leaves it
  always_comb begin
    flag_set = sbtc_pkg::RST_FLAGS;
    flag_set[sbtc_pkg::BIT_OVF] = ovf_set;
    flag_set[sbtc_pkg::BIT_CMPA] = timer_tick && o_match_a && !cmp_block_reg;
    flag_set[sbtc_pkg::BIT_CMPB] = timer_tick && o_match_b && !cmp_block_reg;
    flag_set[sbtc_pkg::BIT_CAP] = cap_edge && !cap_is_top;
  end

  // per-flag next value: hardware set beats clear
  for (genvar g = 0; g < 4; g++) begin : g_flag
    assign flag_clr[g] = i_irq_ack[g]
      || (wr_en && i_address == sbtc_pkg::ADDR_FLAG && wbyte[g]);
    assign flag_next[g] = flag_set[g] || (flag_reg[g] && !flag_clr[g]);
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      flag_reg <= sbtc_pkg::RST_FLAGS;
    end else begin
      flag_reg <= flag_next;
    end
  end
endmodule : sbtc_core

// >>> sim/sbtc_core_monitor.sv
// Purpose: bus and status checks for the timer core
// Assumes: one clock, sync active-low reset
// Notes: bound to every core instance
`timescale 1ns/100ps
module sbtc_core_monitor (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // bus
  input wire logic [5:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  input wire logic [1:0] o_response,
  // pins and status
  input wire logic i_capture_input_pin,
  input wire logic [3:0] i_irq_ack,
  input wire logic [3:0] o_irq,
  input wire logic o_bottom,
  input wire logic o_max,
  input wire logic o_top
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  sequence s_req;
    (i_read || i_write) && o_waitrequest;
  endsequence
  sequence s_done;
    !o_waitrequest ##1 o_waitrequest;
  endsequence
  a_one_wait: assert property (s_req |=> s_done)
    else $error("bus wait not one cycle");
  a_idle_wait: assert property (!(i_read || i_write) |=> o_waitrequest)
    else $error("waitrequest low while idle");
  a_resp_okay: assert property (o_response == 2'h0)
    else $error("response not okay");
  a_read_upper: assert property (i_read && !o_waitrequest |-> o_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_unmapped_zero: assert property (i_read && !o_waitrequest && i_address > 6'h2C
    |-> o_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_reset_clear: assert property ($rose(i_nrst) |-> o_irq == 4'h0 && o_bottom && !o_top)
    else $error("state not clear after reset");
  a_bottom_max: assert property (!(o_bottom && o_max))
    else $error("bottom and max together");
  a_ack_clear: assert property (i_irq_ack[3] && $stable(i_capture_input_pin)
    |=> !o_irq[3])
    else $error("acknowledge did not clear flag");
endmodule : sbtc_core_monitor

bind sbtc_core sbtc_core_monitor i_sbtc_core_monitor (
  .i_clock(i_clock), .i_nrst(i_nrst), .i_address(i_address), .i_read(i_read),
  .i_write(i_write), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
  .o_response(o_response), .i_capture_input_pin(i_capture_input_pin),
  .i_irq_ack(i_irq_ack), .o_irq(o_irq), .o_bottom(o_bottom), .o_max(o_max),
  .o_top(o_top)
);

// >>> sim/sbtc_cpu_model.sv
// Purpose: processor-side bus master for the timer core
// Assumes: one request at a time, byte data in bits 7:0
// Notes: answer sampled at the rising edge with waitrequest low
`timescale 1ns/100ps
module sbtc_cpu_model (
  // clock
  input wire logic i_clock,
  // avalon-mm master
  input wire logic [31:0] i_readdata,
  input wire logic i_waitrequest,
  output logic [5:0] o_address,
  output logic o_read,
  output logic o_write,
  output logic [31:0] o_writedata,
  output logic [3:0] o_byteenable,
  // status
  output logic o_timeout
);
  initial begin
    o_address = 6'h00;
    o_read = 1'b0;
    o_write = 1'b0;
    o_writedata = 32'h0;
    o_byteenable = 4'h1;
    o_timeout = 1'b0;
  end
  task automatic acc(input logic we, input logic [5:0] a, input logic [7:0] d,
    output logic [7:0] q);
    int n;
    n = 0;
    o_address <= a;
    o_write <= we;
    o_read <= !we;
    o_writedata <= {24'h0, d};
    do begin
      @(posedge i_clock);
      n++;
    end while (i_waitrequest && n < 60);
    o_timeout <= i_waitrequest;
    q = i_readdata[7:0];
    o_read <= 1'b0;
    o_write <= 1'b0;
    @(posedge i_clock);
  endtask : acc
  task automatic wr16(input logic [5:0] a, input logic [15:0] v);
    logic [7:0] q;
    acc(1'b1, a + 6'h04, v[15:8], q);
    acc(1'b1, a, v[7:0], q);
  endtask : wr16
  task automatic rd16(input logic [5:0] a, output logic [15:0] v);
    acc(1'b0, a, 8'h00, v[7:0]);
    acc(1'b0, a + 6'h04, 8'h00, v[15:8]);
  endtask : rd16
endmodule : sbtc_cpu_model

// >>> sim/sbtc_core_tb.sv
// Purpose: directed bench for the timer core
// Assumes: pins driven synchronously
// Notes: counting driven from the external pin only
`timescale 1ns/100ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin failures++; \
  $display("mismatch %s expected %h seen %h", n, e, s); end end
module sbtc_core_tb;
  localparam logic [5:0] CB = sbtc_pkg::ADDR_CTRL_B;
  localparam logic [5:0] CNT = sbtc_pkg::ADDR_CNT_LO;
  localparam logic [5:0] FLG = sbtc_pkg::ADDR_FLAG;
  localparam logic [7:0] RISE = {5'h00, sbtc_pkg::CS_EXT_RISE};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ext = 1'b0;
  logic cap = 1'b0;
  logic [3:0] ack = 4'h0;
  logic [5:0] addr;
  logic rd, wr, waitreq, tout, top, bot, mx, ma, mb, pwma;
  logic [31:0] wdata, rdata;
  logic [3:0] be, irq;
  logic [1:0] resp;
  logic [7:0] q;
  logic [15:0] w;
  int failures = 0;
  int checks_done = 0;
  always #5 clk = ~clk;
  sbtc_core i_sbtc_core (
    .i_clock(clk), .i_nrst(nrst), .i_address(addr), .i_read(rd), .i_write(wr),
    .i_writedata(wdata), .i_byteenable(be), .o_readdata(rdata),
    .o_waitrequest(waitreq), .o_response(resp), .i_external_count_input(ext),
    .i_capture_input_pin(cap), .i_comparator_out(1'b0),
    .i_capture_use_comparator(1'b0), .i_irq_ack(ack), .o_irq(irq), .o_top(top),
    .o_bottom(bot), .o_max(mx), .o_match_a(ma), .o_match_b(mb), .o_pwm_a_enable(pwma)
  );
  sbtc_cpu_model i_sbtc_cpu_model (
    .i_clock(clk), .i_readdata(rdata), .i_waitrequest(waitreq), .o_address(addr),
    .o_read(rd), .o_write(wr), .o_writedata(wdata), .o_byteenable(be), .o_timeout(tout)
  );
  task automatic wrap_up();
    if (failures == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic wr8(input logic [5:0] a, input logic [7:0] d);
    i_sbtc_cpu_model.acc(1'b1, a, d, q);
  endtask : wr8
  task automatic rd8(input logic [5:0] a);
    i_sbtc_cpu_model.acc(1'b0, a, 8'h00, q);
  endtask : rd8
  task automatic pulse(input int n);
    repeat (2 * n) begin
      ext <= ~ext;
      repeat (4) @(posedge clk);
    end
  endtask : pulse
  always @(posedge tout) begin
    failures++;
    wrap_up();
  end
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 13; k++) begin
      rd8(6'(4 * k));
      `CHK("reset byte", 8'h00, q)
    end
    wr8(sbtc_pkg::ADDR_CTRL_A, 8'h03);
    rd8(sbtc_pkg::ADDR_CTRL_A);
    `CHK("ctrl a", 8'h03, q)
    i_sbtc_cpu_model.wr16(CNT, sbtc_pkg::CNT_MAX);
    `CHK("top", 1'b1, top)
    `CHK("max", 1'b1, mx)
    `CHK("pwm a on", 1'b1, pwma)
    wr8(CB, 8'h10);
    rd8(CB);
    `CHK("ctrl b", 8'h10, q)
    `CHK("pwm a off", 1'b0, pwma)
    wr8(sbtc_pkg::ADDR_CTRL_A, 8'h00);
    wr8(CB, 8'h00);
    i_sbtc_cpu_model.wr16(CNT, 16'h1234);
    wr8(sbtc_pkg::ADDR_CNT_HI, 8'h56);
    pulse(2);
    i_sbtc_cpu_model.rd16(CNT, w);
    `CHK("count held", 16'h1234, w)
    for (int k = 0; k < 2; k++) begin
      wr8(CB, k ? {5'h00, sbtc_pkg::CS_EXT_FALL} : RISE);
      pulse(3);
      wr8(CB, 8'h00);
      i_sbtc_cpu_model.rd16(CNT, w);
      `CHK("ext count", 16'h1237 + 16'(3 * k), w)
    end
    i_sbtc_cpu_model.wr16(sbtc_pkg::ADDR_CMPA_LO, 16'h0010);
    i_sbtc_cpu_model.wr16(sbtc_pkg::ADDR_CMPB_LO, 16'h0011);
    i_sbtc_cpu_model.wr16(CNT, 16'h000F);
    wr8(sbtc_pkg::ADDR_MASK, 8'h0C);
    wr8(CB, RISE);
    for (int k = 0; k < 3; k++) begin
      pulse(1);
      rd8(FLG);
      `CHK("cmp flags", {5'h00, k == 2, k > 0, 1'b0}, q)
      `CHK("irq", {1'b0, k == 2, 2'b00}, irq)
      `CHK("match a", k == 0, ma)
      `CHK("match b", k == 1, mb)
    end
    wr8(CB, 8'h00);
    ack <= 4'h2;
    @(posedge clk);
    ack <= 4'h0;
    rd8(FLG);
    `CHK("ack a", 8'h04, q)
    i_sbtc_cpu_model.wr16(CNT, 16'hFFFF);
    wr8(CB, RISE);
    pulse(1);
    wr8(CB, 8'h40);
    `CHK("bottom", 1'b1, bot)
    rd8(FLG);
    `CHK("overflow", 8'h05, q)
    i_sbtc_cpu_model.wr16(CNT, 16'h4321);
    cap <= 1'b1;
    repeat (4) @(posedge clk);
    i_sbtc_cpu_model.rd16(sbtc_pkg::ADDR_CAP_LO, w);
    `CHK("capture", 16'h4321, w)
    rd8(FLG);
    `CHK("cap flag", 8'h0D, q)
    `CHK("cap irq", 4'hC, irq)
    ack <= 4'h8;
    @(posedge clk);
    ack <= 4'h0;
    rd8(FLG);
    `CHK("ack cap", 8'h05, q)
    wr8(FLG, 8'h05);
    rd8(FLG);
    `CHK("write one", 8'h00, q)
    wr8(sbtc_pkg::ADDR_CTRL_A, 8'h03);
    wr8(CB, 8'h18);
    i_sbtc_cpu_model.wr16(sbtc_pkg::ADDR_CMPA_LO, 16'h0020);
    i_sbtc_cpu_model.wr16(CNT, 16'h0010);
    `CHK("old top", 1'b1, top)
    wr8(CB, 8'h1F);
    pulse(1);
    wr8(CB, 8'h18);
    i_sbtc_cpu_model.wr16(CNT, 16'h0020);
    `CHK("new top", 1'b1, top)
    wrap_up();
  end
endmodule : sbtc_core_tb
